// >>> pkg/rpsp_map.svh
// Purpose: Register offsets, defaults, ranges and timing for the receiver parameter setup panel.
// Assumes: 25 MHz CLK, APB register access with 32-bit data.
// Notes: Threshold and barrier number values are held as two BCD digits, tens in the upper nibble; enables as single bits.
// Summary of operation
// - Selector 5 adjusts the masking threshold, applied on both sides of the stored installation level.
// - At adjustment positions, tens and units indicators light when each switch equals the stored digit; at 0, 1, 2, D and E both stay dark.
// - Store button replaces the selected parameter with the dialled two-digit value.
// - Masking threshold accepts 05 to 80, default 60.
// - A lower masking threshold lets a smaller field change raise masking alarm.
// - Storing the prealarm threshold sets both prealarm thresholds to one value.
// - Selector 6 adjusts higher prealarm threshold, range 05 to 80, default 15.
// - Selector 7 adjusts higher alarm threshold, range 05 to 80, default 30.
// - Selector 8 sets barrier number 01 to 99; 00 means 100, the default.
// - The barrier number is the receiver's unique address on the shared bus.
// - Selector 9 sets monitor threshold, default 15; exceeding it starts recording.
// - Selector B sets battery test enable: 00 off, 01 on, default off.
// - Selector C sets prealarm save enable: 01 records, 00 suppresses, default 00.
// - Selector F sets balanced-line enable: 01 on, 00 off, default off.
// - Selector 0 and store button commit all parameters to non-volatile storage.
// - Installation reference is the AGC level and channel captured at acquisition.
`ifndef RPSP_MAP_SVH
`define RPSP_MAP_SVH
`define RPSP_OFF_CTRL      8'h00
`define RPSP_OFF_STATUS    8'h04
`define RPSP_OFF_MASK      8'h08
`define RPSP_OFF_PARAM_A   8'h0C
`define RPSP_OFF_PARAM_B   8'h10
`define RPSP_OFF_PARAM_C   8'h14
`define RPSP_OFF_REF       8'h18
`define RPSP_OFF_NV_A      8'h1C
`define RPSP_OFF_NV_B      8'h20
`define RPSP_OFF_NV_C      8'h24
`define RPSP_CTRL_LOCK     0
`define RPSP_DEF_MASKING   8'h60
`define RPSP_DEF_PREALARM  8'h15
`define RPSP_DEF_ALARM     8'h30
`define RPSP_DEF_BUS       8'h00
`define RPSP_DEF_MONITOR   8'h15
`define RPSP_THR_MIN       7'h05
`define RPSP_THR_MAX       7'h50
`define RPSP_CLK_HZ        25000000
`define RPSP_DEBOUNCE_MS   20
`define RPSP_DEBOUNCE_CYC  (`RPSP_DEBOUNCE_MS * (`RPSP_CLK_HZ / 1000))
`endif

// >>> pkg/rpsp_pkg.sv
// Purpose: Types shared by the receiver parameter setup panel.
// Assumes: Nothing beyond standard SystemVerilog.
// Notes: Selector codes follow the panel's printed positions.
package rpsp_pkg;
   typedef logic [7:0] rpsp_bcd_t;
   typedef enum logic [3:0] {
      RPSP_SEL_COMMIT   = 4'h0,
      RPSP_SEL_ALIGN    = 4'h1,
      RPSP_SEL_ACQUIRE  = 4'h2,
      RPSP_SEL_PREALARM = 4'h3,
      RPSP_SEL_ALARM    = 4'h4,
      RPSP_SEL_MASKING  = 4'h5,
      RPSP_SEL_HI_PRE   = 4'h6,
      RPSP_SEL_HI_ALARM = 4'h7,
      RPSP_SEL_BUS      = 4'h8,
      RPSP_SEL_MONITOR  = 4'h9,
      RPSP_SEL_HI_MON   = 4'hA,
      RPSP_SEL_BATTERY  = 4'hB,
      RPSP_SEL_PRE_SAVE = 4'hC,
      RPSP_SEL_SPARE_D  = 4'hD,
      RPSP_SEL_SPARE_E  = 4'hE,
      RPSP_SEL_BAL_LINE = 4'hF
   } rpsp_sel_t;
   typedef struct packed {
      rpsp_bcd_t masking;
      rpsp_bcd_t prealarm;
      rpsp_bcd_t hi_prealarm;
      rpsp_bcd_t alarm;
      rpsp_bcd_t hi_alarm;
      rpsp_bcd_t bus_number;
      rpsp_bcd_t monitor;
      rpsp_bcd_t hi_monitor;
      logic      battery_test;
      logic      prealarm_save;
      logic      balanced_line;
   } rpsp_params_t;
   typedef struct packed {
      logic [7:0] agc_level;
      logic [7:0] channel;
   } rpsp_ref_t;
   typedef struct packed {
      logic capture;
      logic record_start;
      logic masking_alarm;
      logic commit;
      logic store_rejected;
      logic store_accepted;
   } rpsp_events_t;
endpackage

// >>> design/rpsp_panel.sv
// Purpose: Parameter setup panel of the barrier receiver with APB register access.
// Assumes: Switch, button and field inputs are synchronous to CLK.
// Notes: CE low freezes every flip-flop of the block.
`timescale 1ns/1ps
`default_nettype none
`include "rpsp_map.svh"
module rpsp_panel #(
   parameter int unsigned DEBOUNCE_CYCLES = `RPSP_DEBOUNCE_CYC
) (
   input  wire logic        CLK,
   input  wire logic        NRST,
   input  wire logic        CE,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic [3:0]  FUNCTION_SELECTOR,
   input  wire logic [3:0]  TENS_DIGIT_SWITCH,
   input  wire logic [3:0]  UNITS_DIGIT_SWITCH,
   input  wire logic        STORE_BUTTON,
   input  wire logic [7:0]  INSTALLATION_AGC_LEVEL,
   input  wire logic [7:0]  CHANNEL_NUMBER,
   input  wire logic [7:0]  ABS_FIELD_LEVEL,
   input  wire logic [7:0]  REST_FIELD_LEVEL,
   output logic             TENS_MATCH_INDICATOR,
   output logic             UNITS_MATCH_INDICATOR,
   output logic [6:0]       BARRIER_ADDRESS,
   output logic             SIDE_TARGET_DISCRIMINATION,
   output logic             MASKING_ALARM,
   output logic             RECORD_START,
   output logic             BATTERY_TEST_EN,
   output logic             PREALARM_SAVE_EN,
   output logic             BALANCED_LINE_EN,
   output logic             NV_WRITE,
   output logic             IRQ
);

   localparam int unsigned DB_W = (DEBOUNCE_CYCLES > 1) ? $clog2(DEBOUNCE_CYCLES + 1) : 1;

   // Converts a two-digit BCD value to binary.
   function automatic logic [6:0] bcd2bin(input rpsp_pkg::rpsp_bcd_t b);
      logic [6:0] t;
      t = 7'(b[7:4]) * 7'h0A;
      return 7'(t + 7'(b[3:0]));
   endfunction

   // Checks a dialled value against the range of the selected parameter.
   function automatic logic in_range(input logic [3:0] sel, input rpsp_pkg::rpsp_bcd_t b);
      logic [6:0] v;
      logic       ok;
      v  = bcd2bin(b);
      ok = 1'b0;
      if ((b[7:4] <= 4'h9) && (b[3:0] <= 4'h9)) begin
         unique case (sel)
            4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA: begin
               ok = (v >= `RPSP_THR_MIN) && (v <= `RPSP_THR_MAX);
            end
            4'h8: begin
               ok = 1'b1;
            end
            4'hB, 4'hC, 4'hF: begin
               ok = (b == 8'h00) || (b == 8'h01);
            end
            default: begin
               ok = 1'b0;
            end
         endcase
      end
      return ok;
   endfunction

   // Returns the stored value of the parameter at a selector position.
   function automatic rpsp_pkg::rpsp_bcd_t stored_of(input logic [3:0] sel,
                                                     input rpsp_pkg::rpsp_params_t p);
      rpsp_pkg::rpsp_bcd_t r;
      r = 8'h00;
      unique case (sel)
         4'h3:    r = p.prealarm;
         4'h4:    r = p.alarm;
         4'h5:    r = p.masking;
         4'h6:    r = p.hi_prealarm;
         4'h7:    r = p.hi_alarm;
         4'h8:    r = p.bus_number;
         4'h9:    r = p.monitor;
         4'hA:    r = p.hi_monitor;
         4'hB:    r = {7'h00, p.battery_test};
         4'hC:    r = {7'h00, p.prealarm_save};
         4'hF:    r = {7'h00, p.balanced_line};
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // Saturating window of a reference level widened by a threshold.
   function automatic logic outside(input logic [7:0] lvl, input logic [7:0] ref_lvl,
                                    input logic [6:0] lo_thr, input logic [6:0] hi_thr);
      logic [8:0] hi;
      logic [8:0] lo;
      hi = 9'(ref_lvl) + 9'(hi_thr);
      lo = 9'(lvl) + 9'(lo_thr);
      return (9'(lvl) > hi) || (lo < 9'(ref_lvl));
   endfunction

   rpsp_pkg::rpsp_params_t params_r;
   rpsp_pkg::rpsp_params_t nv_r;
   rpsp_pkg::rpsp_ref_t    ref_r;
   rpsp_pkg::rpsp_events_t ev;
   rpsp_pkg::rpsp_events_t status_r;
   rpsp_pkg::rpsp_events_t mask_r;
   rpsp_pkg::rpsp_bcd_t    dialled;
   rpsp_pkg::rpsp_bcd_t    stored;
   logic [DB_W-1:0]        db_cnt_r;
   logic                   btn_stable_r;
   logic                   btn_prev_r;
   logic                   press;
   logic                   lock_r;
   logic                   value_ok;
   logic                   mask_cond;
   logic                   rec_cond;
   logic                   rec_prev_r;
   logic                   apb_access;
   logic                   apb_write;
   logic [31:0]            rdata_nxt;
   logic                   err_nxt;

   assign dialled    = {TENS_DIGIT_SWITCH, UNITS_DIGIT_SWITCH};
   assign stored     = stored_of(FUNCTION_SELECTOR, params_r);
   assign value_ok   = in_range(FUNCTION_SELECTOR, dialled);
   assign apb_access = PSEL && PENABLE && !PREADY;
   assign apb_write  = apb_access && PWRITE;

   // Debounces the store button and yields one pulse per press.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         db_cnt_r     <= '0;
         btn_stable_r <= 1'b0;
         btn_prev_r   <= 1'b0;
      end else if (CE) begin
         btn_prev_r <= btn_stable_r;
         if (STORE_BUTTON == btn_stable_r) begin
            db_cnt_r <= '0;
         end else if (db_cnt_r >= DB_W'(DEBOUNCE_CYCLES - 1)) begin
            db_cnt_r     <= '0;
            btn_stable_r <= STORE_BUTTON;
         end else begin
            db_cnt_r <= db_cnt_r + 1'b1;
         end
      end
   end

   assign press = btn_stable_r && !btn_prev_r && !lock_r;

   // Applies a press to the parameter selected on the panel.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         params_r.masking       <= `RPSP_DEF_MASKING;
         params_r.prealarm      <= `RPSP_DEF_PREALARM;
         params_r.hi_prealarm   <= `RPSP_DEF_PREALARM;
         params_r.alarm         <= `RPSP_DEF_ALARM;
         params_r.hi_alarm      <= `RPSP_DEF_ALARM;
         params_r.bus_number    <= `RPSP_DEF_BUS;
         params_r.monitor       <= `RPSP_DEF_MONITOR;
         params_r.hi_monitor    <= `RPSP_DEF_MONITOR;
         params_r.battery_test  <= 1'b0;
         params_r.prealarm_save <= 1'b0;
         params_r.balanced_line <= 1'b0;
      end else if (CE && press && value_ok) begin
         unique case (FUNCTION_SELECTOR)
            4'h3: begin
               params_r.prealarm    <= dialled;
               params_r.hi_prealarm <= dialled;
            end
            4'h4: params_r.alarm         <= dialled;
            4'h5: params_r.masking       <= dialled;
            4'h6: params_r.hi_prealarm   <= dialled;
            4'h7: params_r.hi_alarm      <= dialled;
            4'h8: params_r.bus_number    <= dialled;
            4'h9: params_r.monitor       <= dialled;
            4'hA: params_r.hi_monitor    <= dialled;
            4'hB: params_r.battery_test  <= dialled[0];
            4'hC: params_r.prealarm_save <= dialled[0];
            4'hF: params_r.balanced_line <= dialled[0];
            default: params_r <= params_r;
         endcase
      end
   end

   // Captures the installation reference during acquisition.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ref_r <= '0;
      end else if (CE && press && (FUNCTION_SELECTOR == 4'h2)) begin
         ref_r.agc_level <= INSTALLATION_AGC_LEVEL;
         ref_r.channel   <= CHANNEL_NUMBER;
      end
   end

   // Commits the working set to the non-volatile image.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         nv_r     <= '0;
         NV_WRITE <= 1'b0;
      end else if (CE) begin
         NV_WRITE <= press && (FUNCTION_SELECTOR == 4'h0);
         if (press && (FUNCTION_SELECTOR == 4'h0)) begin
            nv_r <= params_r;
         end
      end
   end

   // Drives the match indicators and the parameter outputs.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         TENS_MATCH_INDICATOR       <= 1'b0;
         UNITS_MATCH_INDICATOR      <= 1'b0;
         BARRIER_ADDRESS            <= 7'h64;
         SIDE_TARGET_DISCRIMINATION <= 1'b0;
         BATTERY_TEST_EN            <= 1'b0;
         PREALARM_SAVE_EN           <= 1'b0;
         BALANCED_LINE_EN           <= 1'b0;
      end else if (CE) begin
         if (FUNCTION_SELECTOR inside {4'h0, 4'h1, 4'h2, 4'hD, 4'hE}) begin
            TENS_MATCH_INDICATOR  <= 1'b0;
            UNITS_MATCH_INDICATOR <= 1'b0;
         end else begin
            TENS_MATCH_INDICATOR  <= (TENS_DIGIT_SWITCH == stored[7:4]);
            UNITS_MATCH_INDICATOR <= (UNITS_DIGIT_SWITCH == stored[3:0]);
         end
         if (params_r.bus_number == 8'h00) begin
            BARRIER_ADDRESS <= 7'h64;
         end else begin
            BARRIER_ADDRESS <= bcd2bin(params_r.bus_number);
         end
         SIDE_TARGET_DISCRIMINATION <=
            (bcd2bin(params_r.hi_prealarm) > bcd2bin(params_r.prealarm)) &&
            (bcd2bin(params_r.hi_alarm) > bcd2bin(params_r.alarm));
         BATTERY_TEST_EN  <= params_r.battery_test;
         PREALARM_SAVE_EN <= params_r.prealarm_save;
         BALANCED_LINE_EN <= params_r.balanced_line;
      end
   end

   // Evaluates the masking window and the monitor window.
   assign mask_cond = outside(ABS_FIELD_LEVEL, ref_r.agc_level,
                              bcd2bin(params_r.masking), bcd2bin(params_r.masking));
   assign rec_cond  = outside(ABS_FIELD_LEVEL, REST_FIELD_LEVEL,
                              bcd2bin(params_r.monitor), bcd2bin(params_r.hi_monitor));

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         MASKING_ALARM <= 1'b0;
         RECORD_START  <= 1'b0;
         rec_prev_r    <= 1'b0;
      end else if (CE) begin
         MASKING_ALARM <= mask_cond;
         rec_prev_r    <= rec_cond;
         RECORD_START  <= rec_cond && !rec_prev_r;
      end
   end

   assign ev.store_accepted = press && value_ok;
   assign ev.store_rejected = press && !value_ok &&
                              !(FUNCTION_SELECTOR inside {4'h0, 4'h2});
   assign ev.commit         = press && (FUNCTION_SELECTOR == 4'h0);
   assign ev.masking_alarm  = mask_cond && !MASKING_ALARM;
   assign ev.record_start   = rec_cond && !rec_prev_r;
   assign ev.capture        = press && (FUNCTION_SELECTOR == 4'h2);

   // Holds sticky events; a new event wins over a write-one clear.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         status_r <= '0;
      end else if (CE) begin
         if (apb_write && (PADDR == `RPSP_OFF_STATUS)) begin
            status_r <= (status_r & ~PWDATA[5:0]) | ev;
         end else begin
            status_r <= status_r | ev;
         end
      end
   end

   // Holds the control and mask registers and the interrupt line.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         lock_r <= 1'b0;
         mask_r <= '0;
         IRQ    <= 1'b0;
      end else if (CE) begin
         if (apb_write && (PADDR == `RPSP_OFF_CTRL)) begin
            lock_r <= PWDATA[`RPSP_CTRL_LOCK];
         end
         if (apb_write && (PADDR == `RPSP_OFF_MASK)) begin
            mask_r <= PWDATA[5:0];
         end
         IRQ <= |(status_r & mask_r);
      end
   end

   // Decodes reads and unmapped addresses.
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      err_nxt   = 1'b0;
      unique case (PADDR)
         `RPSP_OFF_CTRL:    rdata_nxt = {31'h0, lock_r};
         `RPSP_OFF_STATUS:  rdata_nxt = {26'h0, status_r};
         `RPSP_OFF_MASK:    rdata_nxt = {26'h0, mask_r};
         `RPSP_OFF_PARAM_A: rdata_nxt = {params_r.hi_alarm, params_r.alarm,
                                         params_r.hi_prealarm, params_r.prealarm};
         `RPSP_OFF_PARAM_B: rdata_nxt = {params_r.hi_monitor, params_r.monitor,
                                         params_r.bus_number, params_r.masking};
         `RPSP_OFF_PARAM_C: rdata_nxt = {29'h0, params_r.balanced_line,
                                         params_r.prealarm_save, params_r.battery_test};
         `RPSP_OFF_REF:     rdata_nxt = {16'h0, ref_r};
         `RPSP_OFF_NV_A:    rdata_nxt = {nv_r.hi_alarm, nv_r.alarm,
                                         nv_r.hi_prealarm, nv_r.prealarm};
         `RPSP_OFF_NV_B:    rdata_nxt = {nv_r.hi_monitor, nv_r.monitor,
                                         nv_r.bus_number, nv_r.masking};
         `RPSP_OFF_NV_C:    rdata_nxt = {29'h0, nv_r.balanced_line,
                                         nv_r.prealarm_save, nv_r.battery_test};
         default:           err_nxt   = 1'b1;
      endcase
   end

   // Answers each access one cycle after its access phase begins.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else if (CE) begin
         PREADY  <= apb_access;
         PSLVERR <= apb_access && err_nxt;
         if (apb_access && !PWRITE && !err_nxt) begin
            PRDATA <= rdata_nxt;
         end else begin
            PRDATA <= 32'h0000_0000;
         end
      end
   end

endmodule
`default_nettype wire

// >>> testbench/rpsp_panel_chk.sv
// Purpose: Port assertions for the receiver parameter setup panel.
// Assumes: CE is held high by the bench.
// Notes: Bound into rpsp_panel below the module.
`timescale 1ns/1ps
`default_nettype none
module rpsp_panel_chk #(
   parameter int unsigned DEBOUNCE_CYCLES = 4
) (
   input wire logic        CLK,
   input wire logic        NRST,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic [31:0] PRDATA,
   input wire logic [3:0]  FUNCTION_SELECTOR,
   input wire logic        STORE_BUTTON,
   input wire logic        TENS_MATCH_INDICATOR,
   input wire logic        UNITS_MATCH_INDICATOR,
   input wire logic [6:0]  BARRIER_ADDRESS,
   input wire logic        NV_WRITE,
   input wire logic        RECORD_START
);
   logic [19:0] held_r;
   logic        btn_r;
   // Counts edges since the raw button last rose.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         held_r <= 20'h00000;
         btn_r  <= 1'b0;
      end else begin
         btn_r <= STORE_BUTTON;
         if (STORE_BUTTON && !btn_r) begin
            held_r <= 20'h00000;
         end else if (held_r != 20'hFFFFF) begin
            held_r <= held_r + 20'h00001;
         end
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   sequence s_access;
      PSEL && PENABLE && !PREADY;
   endsequence
   sequence s_answer;
      PREADY ##1 !PREADY;
   endsequence
   property p_one_wait;
      s_access |=> s_answer;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("APB answer not one pulse after wait");
   property p_err;
      PSLVERR |-> PREADY && PRDATA == 32'h00000000;
   endproperty
   a_err: assert property (p_err) else $error("Error answer without zero data");
   property p_leds_off;
      FUNCTION_SELECTOR inside {4'h0, 4'h1, 4'h2, 4'hD, 4'hE}
         |=> !TENS_MATCH_INDICATOR && !UNITS_MATCH_INDICATOR;
   endproperty
   a_leds_off: assert property (p_leds_off) else $error("Indicator lit outside adjustment");
   property p_addr;
      BARRIER_ADDRESS inside {[7'h01:7'h64]};
   endproperty
   a_addr: assert property (p_addr) else $error("Barrier address out of range");
   property p_addr_src;
      $changed(BARRIER_ADDRESS) |-> FUNCTION_SELECTOR == 4'h8;
   endproperty
   a_addr_src: assert property (p_addr_src) else $error("Address changed off position 8");
   property p_nv_once;
      NV_WRITE |=> !NV_WRITE [*3];
   endproperty
   a_nv_once: assert property (p_nv_once) else $error("Commit pulse repeated");
   property p_nv_held;
      NV_WRITE |-> held_r >= DEBOUNCE_CYCLES - 1;
   endproperty
   a_nv_held: assert property (p_nv_held) else $error("Commit before debounce span");
   property p_nv_commit;
      NV_WRITE |-> FUNCTION_SELECTOR == 4'h0;
   endproperty
   a_nv_commit: assert property (p_nv_commit) else $error("Commit off position 0");
   property p_rec;
      RECORD_START |=> !RECORD_START;
   endproperty
   a_rec: assert property (p_rec) else $error("Recording start not a pulse");
endmodule
bind rpsp_panel rpsp_panel_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_rpsp_panel_chk (
   .CLK, .NRST, .PSEL, .PENABLE, .PREADY, .PSLVERR, .PRDATA, .FUNCTION_SELECTOR,
   .STORE_BUTTON, .TENS_MATCH_INDICATOR, .UNITS_MATCH_INDICATOR, .BARRIER_ADDRESS,
   .NV_WRITE, .RECORD_START
);
`default_nettype wire

// >>> testbench/rpsp_installer.sv
// Purpose: Installer at the panel: selector, decimal switches and store button.
// Assumes: All changes follow a rising edge.
// Notes: Release time covers the debounce span before the next press.
`timescale 1ns/1ps
`default_nettype none
module rpsp_installer #(
   parameter int REL_CYCLES = 8
) (
   input  wire logic  CLK,
   output logic [3:0] FUNCTION_SELECTOR,
   output logic [3:0] TENS_DIGIT_SWITCH,
   output logic [3:0] UNITS_DIGIT_SWITCH,
   output logic       STORE_BUTTON
);
   initial begin
      FUNCTION_SELECTOR  = 4'h0;
      TENS_DIGIT_SWITCH  = 4'h0;
      UNITS_DIGIT_SWITCH = 4'h0;
      STORE_BUTTON       = 1'b0;
   end
   // Turns the selector and both digits, then lets the indicators settle.
   task automatic dial(input logic [3:0] sel, input logic [3:0] tens, input logic [3:0] units);
      @(posedge CLK);
      FUNCTION_SELECTOR  <= sel;
      TENS_DIGIT_SWITCH  <= tens;
      UNITS_DIGIT_SWITCH <= units;
      repeat (3) @(posedge CLK);
   endtask
   // Holds the button for the given span, then keeps it released.
   task automatic press(input int hold);
      @(posedge CLK);
      STORE_BUTTON <= 1'b1;
      repeat (hold) @(posedge CLK);
      STORE_BUTTON <= 1'b0;
      repeat (REL_CYCLES) @(posedge CLK);
   endtask
endmodule
`default_nettype wire

// >>> testbench/receiver_parameter_setup_panel_tb.sv
// Purpose: Self-checking bench of the receiver parameter setup panel.
// Assumes: Short debounce span; CE held high.
// Notes: Installer model drives the panel.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin mismatches++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, (e), (s)); end end
module receiver_parameter_setup_panel_tb;
   localparam int DEB = 4;
   logic        clk     = 1'b0;
   logic        nrst    = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h00000000;
   logic [7:0]  agc     = 8'hC0;
   logic [7:0]  abs_lvl = 8'hC0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  sel;
   logic [3:0]  tens;
   logic [3:0]  units;
   logic        btn;
   logic        tens_led;
   logic        units_led;
   logic [6:0]  addr;
   logic        std;
   logic        mask_alm;
   logic        rec;
   logic        bat_en;
   logic        save_en;
   logic        bal_en;
   logic        nv_wr;
   logic        irq;
   logic [31:0] q;
   logic        err;
   int          nv_cnt = 0;
   int          mismatches = 0;
   int          tests_run = 0;
   always #20 clk = ~clk;
   always @(posedge clk) if (nv_wr === 1'b1) nv_cnt <= nv_cnt + 1;
   rpsp_panel #(.DEBOUNCE_CYCLES(DEB)) u_rpsp_panel (
      .CLK(clk), .NRST(nrst), .CE(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .FUNCTION_SELECTOR(sel), .TENS_DIGIT_SWITCH(tens), .UNITS_DIGIT_SWITCH(units),
      .STORE_BUTTON(btn), .INSTALLATION_AGC_LEVEL(agc), .CHANNEL_NUMBER(8'h07),
      .ABS_FIELD_LEVEL(abs_lvl), .REST_FIELD_LEVEL(8'hC0), .TENS_MATCH_INDICATOR(tens_led),
      .UNITS_MATCH_INDICATOR(units_led), .BARRIER_ADDRESS(addr),
      .SIDE_TARGET_DISCRIMINATION(std), .MASKING_ALARM(mask_alm), .RECORD_START(rec),
      .BATTERY_TEST_EN(bat_en), .PREALARM_SAVE_EN(save_en), .BALANCED_LINE_EN(bal_en),
      .NV_WRITE(nv_wr), .IRQ(irq)
   );
   rpsp_installer #(.REL_CYCLES(DEB + 4)) u_rpsp_installer (
      .CLK(clk), .FUNCTION_SELECTOR(sel), .TENS_DIGIT_SWITCH(tens),
      .UNITS_DIGIT_SWITCH(units), .STORE_BUTTON(btn)
   );
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic store(input logic [3:0] s, input logic [7:0] v, input logic [7:0] a,
                        input logic [31:0] e);
      u_rpsp_installer.dial(s, v[7:4], v[3:0]);
      u_rpsp_installer.press(DEB + 4);
      apb(1'b0, a, 32'h00000000);
      `CHK("stored word", e, q)
   endtask
   task automatic t_defaults();
      apb(1'b0, 8'h0C, 32'h00000000);
      `CHK("thresholds", 32'h30301515, q)
      apb(1'b0, 8'h10, 32'h00000000);
      `CHK("masking bus monitor", 32'h15150060, q)
      apb(1'b0, 8'h14, 32'h00000000);
      `CHK("enables", 32'h00000000, q)
      `CHK("address", 7'h64, addr)
   endtask
   task automatic t_leds();
      u_rpsp_installer.dial(4'h5, 4'h6, 4'h0);
      `CHK("both leds", 2'b11, {tens_led, units_led})
      u_rpsp_installer.dial(4'h5, 4'h6, 4'h1);
      `CHK("tens led only", 2'b10, {tens_led, units_led})
      u_rpsp_installer.dial(4'h5, 4'h5, 4'h0);
      `CHK("units led only", 2'b01, {tens_led, units_led})
   endtask
   task automatic t_masking();
      store(4'h5, 8'h25, 8'h10, 32'h15150025);
      store(4'h5, 8'h81, 8'h10, 32'h15150025);
      store(4'h5, 8'h04, 8'h10, 32'h15150025);
      store(4'h5, 8'h80, 8'h10, 32'h15150080);
      u_rpsp_installer.dial(4'h5, 4'h3, 4'h3);
      u_rpsp_installer.press(DEB - 2);
      apb(1'b0, 8'h10, 32'h00000000);
      `CHK("short press", 32'h15150080, q)
   endtask
   task automatic t_bus();
      store(4'h8, 8'h42, 8'h10, 32'h15154280);
      `CHK("address 42", 7'h2A, addr)
      store(4'h8, 8'h00, 8'h10, 32'h15150080);
      `CHK("address 100", 7'h64, addr)
   endtask
   task automatic t_thresholds();
      store(4'h9, 8'h20, 8'h10, 32'h15200080);
      store(4'hA, 8'h30, 8'h10, 32'h30200080);
      store(4'h3, 8'h25, 8'h0C, 32'h30302525);
      store(4'h6, 8'h40, 8'h0C, 32'h30304025);
      `CHK("discrimination off", 1'b0, std)
      store(4'h7, 8'h50, 8'h0C, 32'h50304025);
      `CHK("discrimination on", 1'b1, std)
   endtask
   task automatic t_enables();
      store(4'hB, 8'h01, 8'h14, 32'h00000001);
      store(4'hC, 8'h01, 8'h14, 32'h00000003);
      store(4'hF, 8'h01, 8'h14, 32'h00000007);
      `CHK("enable outputs", 3'b111, {bal_en, save_en, bat_en})
      store(4'hB, 8'h02, 8'h14, 32'h00000007);
      store(4'hB, 8'h00, 8'h14, 32'h00000006);
      `CHK("battery off", 1'b0, bat_en)
   endtask
   task automatic t_reference();
      store(4'h2, 8'h00, 8'h18, 32'h0000C007);
      @(posedge clk);
      abs_lvl <= 8'h80;
      repeat (2) @(posedge clk);
      `CHK("record start", 1'b1, rec)
      repeat (2) @(posedge clk);
      `CHK("no masking alarm", 1'b0, mask_alm)
      store(4'h5, 8'h25, 8'h10, 32'h30200025);
      `CHK("masking alarm", 1'b1, mask_alm)
      abs_lvl <= 8'hC0;
      repeat (4) @(posedge clk);
      `CHK("alarm gone", 1'b0, mask_alm)
   endtask
   task automatic t_irq();
      `CHK("irq masked", 1'b0, irq)
      apb(1'b1, 8'h08, 32'h00000001);
      repeat (2) @(posedge clk);
      `CHK("irq raised", 1'b1, irq)
      apb(1'b1, 8'h04, 32'h0000003F);
      repeat (2) @(posedge clk);
      `CHK("irq cleared", 1'b0, irq)
      apb(1'b0, 8'h04, 32'h00000000);
      `CHK("status clear", 32'h00000000, q)
      apb(1'b0, 8'h30, 32'h00000000);
      `CHK("unmapped error", 33'h100000000, {err, q})
   endtask
   task automatic t_commit();
      int c0;
      c0 = nv_cnt;
      store(4'h0, 8'h00, 8'h20, 32'h30200025);
      `CHK("commit pulses", 1, nv_cnt - c0)
      apb(1'b0, 8'h24, 32'h00000000);
      `CHK("stored enables", 32'h00000006, q)
   endtask
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      t_defaults();
      t_leds();
      t_masking();
      t_bus();
      t_thresholds();
      t_enables();
      t_reference();
      t_irq();
      t_commit();
      conclude();
   end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude();
   end
endmodule
`default_nettype wire
